// *** hw/cld_decoder.sv ***
// Instruction decoder of a character dot-matrix display controller.
`timescale 1ns/1ps
// Overview of operation
// - Decode commands only while instruction set select is high; else ignore.
// - During an internal operation a status read shows busy on bit 7.
// - Clear fills text RAM with spaces, zeroes counter, forces increment.
// - Return home zeroes counter and display shift, keeps text RAM.
// - Extended return-home opcode loads sleep; sleep parks row/column supply, driver D and converter; driver M is always low.
// - Step direction picks counter increment or decrement on RAM accesses.
// - Shift-on-write shifts display on text RAM writes only.
// - Extended entry-mode opcode loads segment order.
// - Display control loads panel, cursor and blink; panel off keeps RAM.
// - Blink toggles cursor pattern every blink interval.
// - Extended function loads wide font, cursor invert and four-line mode.
// - Shift command moves cursor or display one step, right when one.
// - Extended shift opcode loads line shift or line scroll enables.
// - Function set loads bus width, lines, shift/scroll select and invert.
// - Extended function set loads glyph blink and low power instead.
// - Address sets load counter and pick the RAM for data accesses.
// - Extended text address opcode loads the scroll amount.
// - Status read returns busy and counter at once, no busy time.
// - Data access reaches the RAM picked by the last address set, clear or home.
// - Busy lasts long for clear and home, short for control, data time.
// - Icon RAM words hold the icon bits, presented at an output.
// - In 4-bit mode each byte takes two bus transfers.
// - Shift/scroll select only changes while instruction set select is high.
module cld_decoder
  import cld_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_EXEC_CYC,
  parameter int CTRL_CYCLES = CTRL_EXEC_CYC,
  parameter int DATA_CYCLES = DATA_EXEC_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic instruction_set_select,
  input wire logic register_select,
  input wire logic read_write,
  input wire logic strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic busy_flag,
  output logic [6:0] address_counter,
  output cld_cfg_t cfg,
  output logic [6:0] display_offset,
  output logic cursor_blink_phase,
  output logic rows_cols_to_supply,
  output logic ext_driver_d,
  output logic ext_driver_m,
  output logic converter_enable,
  output logic [ICON_DEPTH-1:0][7:0] icon_bits
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (LONG_CYCLES < 1 || LONG_CYCLES >= (1 << BUSY_W) ||
      CTRL_CYCLES < 1 || CTRL_CYCLES >= (1 << BUSY_W) ||
      DATA_CYCLES < 1 || DATA_CYCLES >= (1 << BUSY_W) ||
      BLINK_CYCLES < 1 || BLINK_CYCLES >= (1 << BLINK_W)) begin : g_chk
    $error("cld_decoder: cycle count out of range");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // The bus is asynchronous to our clock, so every pin is resynchronised;
  // the cost is a few cycles of latency that the busy protocol absorbs.
  logic [11:0] pin_s1;
  logic [11:0] pin_s2;
  logic strobe_d;
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      strobe_d <= 1'b0;
    end else begin
      pin_s1 <= {instruction_set_select, register_select, read_write,
                 strobe, data_in};
      pin_s2 <= pin_s1;
      strobe_d <= pin_s2[8];
    end
  end

  logic iset_s;
  logic rs_s;
  logic rw_s;
  logic strobe_s;
  logic [7:0] db_s;
  assign {iset_s, rs_s, rw_s, strobe_s, db_s} = pin_s2;

  logic fall;
  logic rise;
  assign fall = strobe_d & ~strobe_s;
  assign rise = ~strobe_d & strobe_s;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic nib_half;
  logic [3:0] nib_hold;
  logic [BUSY_W-1:0] busy_cnt;
  logic [BLINK_W-1:0] blink_cnt;
  cld_ram_sel_t ram_sel;
  logic [TEXT_DEPTH-1:0][7:0] text_ram;
  logic [GLYPH_DEPTH-1:0][7:0] glyph_ram;

  logic next_nib_half;
  logic [3:0] next_nib_hold;
  logic [BUSY_W-1:0] next_busy_cnt;
  logic [BLINK_W-1:0] next_blink_cnt;
  logic next_blink_phase;
  cld_ram_sel_t next_ram_sel;
  cld_cfg_t next_cfg;
  logic [6:0] next_ac;
  logic [6:0] next_offset;
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic [TEXT_DEPTH-1:0][7:0] next_text;
  logic [GLYPH_DEPTH-1:0][7:0] next_glyph;
  logic [ICON_DEPTH-1:0][7:0] next_icon;

  logic byte_done;
  logic [7:0] byte_val;
  logic fire;
  logic cmd_fire;
  logic [6:0] ac_step;
  logic [7:0] ram_word;

  // ------------------------------------------------------------------
  // Byte assembly and decode
  // ------------------------------------------------------------------
  always_comb begin
    ram_word = text_ram[address_counter];
    if (ram_sel == CLD_RAM_GLYPH) begin
      ram_word = glyph_ram[address_counter[5:0]];
    end else if (ram_sel == CLD_RAM_ICON) begin
      ram_word = icon_bits[address_counter[3:0]];
    end
    ac_step = cfg.increment ? address_counter + 7'h01
                            : address_counter - 7'h01;
    if (ram_sel == CLD_RAM_GLYPH) begin
      ac_step[6] = 1'b0;
    end else if (ram_sel == CLD_RAM_ICON) begin
      ac_step[6:4] = 3'h0;
    end
  end

  always_comb begin
    next_nib_half = nib_half;
    next_nib_hold = nib_hold;
    byte_done = 1'b0;
    byte_val = db_s;
    if (fall) begin
      if (cfg.bus_width_select) begin
        byte_done = 1'b1;
        next_nib_half = 1'b0;
      end else if (!nib_half) begin
        next_nib_hold = db_s[7:4];
        next_nib_half = 1'b1;
      end else begin
        byte_val = {nib_hold, db_s[7:4]};
        byte_done = 1'b1;
        next_nib_half = 1'b0;
      end
    end
  end

  // Commands arriving while busy are dropped: the host is obliged to poll.
  assign fire = byte_done & iset_s & ~busy_flag;
  assign cmd_fire = fire & ~rs_s & ~rw_s;

  always_comb begin
    next_cfg = cfg;
    next_ac = address_counter;
    next_offset = display_offset;
    next_ram_sel = ram_sel;
    next_text = text_ram;
    next_glyph = glyph_ram;
    next_icon = icon_bits;
    next_busy_cnt = (busy_cnt != '0) ? busy_cnt - 1'b1 : busy_cnt;
    next_data_out = data_out;
    next_data_oe = data_oe;
    if (rise && rw_s) begin
      next_data_oe = 1'b1;
      next_data_out = rs_s ? ram_word : {busy_flag, address_counter};
      if (!cfg.bus_width_select && nib_half) begin
        next_data_out = {next_data_out[3:0], 4'h0};
      end else if (!cfg.bus_width_select) begin
        next_data_out = {next_data_out[7:4], 4'h0};
      end
    end else if (fall) begin
      next_data_oe = 1'b0;
    end
    if (fire && rs_s) begin
      next_ac = ac_step;
      next_busy_cnt = BUSY_W'(DATA_CYCLES);
      if (!rw_s) begin
        unique case (ram_sel)
          CLD_RAM_TEXT: begin
            next_text[address_counter] = byte_val;
            // Stepping up shifts left, which is the opposite right.
            if (cfg.shift_on_write) begin
              next_offset = cfg.increment ? display_offset - 7'h01
                                          : display_offset + 7'h01;
            end
          end
          CLD_RAM_GLYPH: next_glyph[address_counter[5:0]] = byte_val;
          CLD_RAM_ICON: next_icon[address_counter[3:0]] = byte_val;
          default: next_ram_sel = CLD_RAM_TEXT;
        endcase
      end
    end else if (cmd_fire) begin
      next_busy_cnt = BUSY_W'(CTRL_CYCLES);
      if (byte_val == OP_CLEAR) begin
        next_text = {TEXT_DEPTH{SPACE_CODE}};
        next_ac = 7'h00;
        next_offset = 7'h00;
        next_ram_sel = CLD_RAM_TEXT;
        next_cfg.increment = 1'b1;
        next_busy_cnt = BUSY_W'(LONG_CYCLES);
      end else if (byte_val[7:1] == 7'h01) begin
        if (cfg.extended_register_enable) begin
          next_cfg.sleep_request = byte_val[0];
        end else begin
          next_ac = 7'h00;
          next_offset = 7'h00;
          next_ram_sel = CLD_RAM_TEXT;
          next_busy_cnt = BUSY_W'(LONG_CYCLES);
        end
      end else if (byte_val[7:2] == 6'h01) begin
        if (cfg.extended_register_enable) begin
          next_cfg.segment_order = byte_val[0];
        end else begin
          next_cfg.increment = byte_val[1];
          next_cfg.shift_on_write = byte_val[0];
        end
      end else if (byte_val[7:3] == 5'h01) begin
        if (cfg.extended_register_enable) begin
          next_cfg.wide_font = byte_val[2];
          next_cfg.cursor_invert = byte_val[1];
          next_cfg.four_line_select = byte_val[0];
        end else begin
          next_cfg.panel_on = byte_val[2];
          next_cfg.cursor_on = byte_val[1];
          next_cfg.cursor_blink = byte_val[0];
        end
      end else if (byte_val[7:4] == 4'h1) begin
        if (cfg.extended_register_enable) begin
          if (cfg.shift_or_scroll_select) begin
            next_cfg.line_shift_enables = byte_val[3:0];
          end else begin
            next_cfg.line_scroll_enables = byte_val[3:0];
          end
        end else if (byte_val[3]) begin
          next_offset = byte_val[2] ? display_offset + 7'h01
                                    : display_offset - 7'h01;
        end else begin
          next_ac = byte_val[2] ? address_counter + 7'h01
                                : address_counter - 7'h01;
        end
      end else if (byte_val[7:5] == 3'h1) begin
        next_cfg.bus_width_select = byte_val[FS_WIDTH_BIT];
        next_cfg.two_line = byte_val[FS_LINES_BIT];
        next_cfg.extended_register_enable = byte_val[FS_EXT_BIT];
        // The byte's own extended bit picks the meaning of its low bits.
        if (byte_val[FS_EXT_BIT]) begin
          next_cfg.glyph_blink_enable = byte_val[1];
          next_cfg.low_power_select = byte_val[0];
        end else begin
          next_cfg.shift_or_scroll_select = byte_val[1];
          next_cfg.invert_whole_display = byte_val[0];
        end
      end else if (byte_val[7:6] == 2'h1) begin
        if (cfg.extended_register_enable) begin
          next_ac = {3'h0, byte_val[3:0]};
          next_ram_sel = CLD_RAM_ICON;
        end else begin
          next_ac = {1'b0, byte_val[5:0]};
          next_ram_sel = CLD_RAM_GLYPH;
        end
      end else if (byte_val[7] && cfg.extended_register_enable) begin
        next_cfg.scroll_amount = byte_val[5:0];
      end else if (byte_val[7]) begin
        next_ac = byte_val[6:0];
        next_ram_sel = CLD_RAM_TEXT;
      end
    end
  end

  // ------------------------------------------------------------------
  // Blink timer
  // ------------------------------------------------------------------
  always_comb begin
    next_blink_cnt = '0;
    next_blink_phase = 1'b0;
    if (cfg.cursor_blink || cfg.cursor_invert) begin
      next_blink_phase = cursor_blink_phase;
      next_blink_cnt = blink_cnt + 1'b1;
      if (blink_cnt == BLINK_W'(BLINK_CYCLES - 1)) begin
        next_blink_cnt = '0;
        next_blink_phase = ~cursor_blink_phase;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      nib_half <= 1'b0;
      nib_hold <= 4'h0;
      busy_cnt <= '0;
      busy_flag <= 1'b0;
      blink_cnt <= '0;
      cursor_blink_phase <= 1'b0;
      ram_sel <= CLD_RAM_TEXT;
      cfg <= CFG_RESET;
      address_counter <= 7'h00;
      display_offset <= 7'h00;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      text_ram <= {TEXT_DEPTH{SPACE_CODE}};
      glyph_ram <= '0;
      icon_bits <= '0;
      rows_cols_to_supply <= 1'b0;
      ext_driver_d <= 1'b0;
      ext_driver_m <= 1'b0;
      converter_enable <= 1'b1;
    end else begin
      nib_half <= next_nib_half;
      nib_hold <= next_nib_hold;
      busy_cnt <= next_busy_cnt;
      busy_flag <= next_busy_cnt != '0;
      blink_cnt <= next_blink_cnt;
      cursor_blink_phase <= next_blink_phase;
      ram_sel <= next_ram_sel;
      cfg <= next_cfg;
      address_counter <= next_ac;
      display_offset <= next_offset;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      text_ram <= next_text;
      glyph_ram <= next_glyph;
      icon_bits <= next_icon;
      rows_cols_to_supply <= next_cfg.sleep_request;
      ext_driver_d <= next_cfg.sleep_request;
      ext_driver_m <= 1'b0;
      converter_enable <= ~next_cfg.sleep_request;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  status_busy_a: assert property (@(posedge clock) disable iff (rst)
    (rise && rw_s && !rs_s && cfg.bus_width_select) |=>
      data_out == {$past(busy_flag), $past(address_counter)} && data_oe)
    else $error("status read does not show busy and counter");

  clear_state_a: assert property (@(posedge clock) disable iff (rst)
    (cmd_fire && byte_val == OP_CLEAR) |=>
      address_counter == 7'h00 && cfg.increment && busy_flag &&
      text_ram[0] == SPACE_CODE)
    else $error("clear did not reset counter and text");

  home_reset_a: assert property (@(posedge clock) disable iff (rst)
    (cmd_fire && byte_val[7:1] == 7'h01 && !cfg.extended_register_enable)
      |=> address_counter == 7'h00 && display_offset == 7'h00)
    else $error("return home left counter or shift");

  sleep_drive_a: assert property (@(posedge clock) disable iff (rst)
    cfg.sleep_request |-> rows_cols_to_supply && !converter_enable)
    else $error("sleep does not park the outputs");

  iset_low_a: assert property (@(posedge clock) disable iff (rst)
    (byte_done && !iset_s) |=> $stable(cfg) && $stable(address_counter))
    else $error("command acted with instruction set select low");

  long_busy_a: assert property (@(posedge clock) disable iff (rst)
    (cmd_fire && byte_val == OP_CLEAR) |=> busy_flag [*8])
    else $error("clear busy period too short");

  shift_write_a: assert property (@(posedge clock) disable iff (rst)
    (fire && rs_s && !rw_s && ram_sel == CLD_RAM_TEXT &&
     cfg.shift_on_write && cfg.increment) |=>
      display_offset == $past(display_offset) - 7'h01)
    else $error("text write did not shift display");

  text_addr_a: assert property (@(posedge clock) disable iff (rst)
    (cmd_fire && byte_val[7] && !cfg.extended_register_enable) |=>
      address_counter == $past(byte_val[6:0]) && ram_sel == CLD_RAM_TEXT)
    else $error("text address set not loaded");

  ext_bit_a: assert property (@(posedge clock) disable iff (rst)
    (cmd_fire && byte_val[7:5] == 3'h1) |=>
      cfg.extended_register_enable == $past(byte_val[FS_EXT_BIT]))
    else $error("function set did not load extended bit");

endmodule

// *** shared/cld_pkg.sv ***
// Shared constants and types of the character display instruction decoder.
package cld_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int LONG_EXEC_NS = 1530000;
  localparam int CTRL_EXEC_NS = 39000;
  localparam int DATA_EXEC_NS = 43000;
  localparam int BLINK_MS = 370;
  localparam int LONG_EXEC_CYC = LONG_EXEC_NS * CLOCK_MHZ / 1000;
  localparam int CTRL_EXEC_CYC = CTRL_EXEC_NS * CLOCK_MHZ / 1000;
  localparam int DATA_EXEC_CYC = DATA_EXEC_NS * CLOCK_MHZ / 1000;
  localparam int BLINK_CYC = BLINK_MS * CLOCK_MHZ * 1000;
  localparam int BUSY_W = 18;
  localparam int BLINK_W = 27;

  // ------------------------------------------------------------------
  // Codes, sizes and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] OP_CLEAR = 8'h01;
  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int ICON_DEPTH = 16;
  localparam logic RST_BUS_WIDTH_8 = 1'b1;
  localparam logic RST_INCREMENT = 1'b1;

  // Field positions inside the command byte.
  localparam int FS_WIDTH_BIT = 4;
  localparam int FS_LINES_BIT = 3;
  localparam int FS_EXT_BIT = 2;

  typedef enum logic [1:0] {
    CLD_RAM_TEXT = 2'b00,
    CLD_RAM_GLYPH = 2'b01,
    CLD_RAM_ICON = 2'b10
  } cld_ram_sel_t;

  typedef struct packed {
    logic panel_on;
    logic cursor_on;
    logic cursor_blink;
    logic wide_font;
    logic cursor_invert;
    logic four_line_select;
    logic bus_width_select;
    logic two_line;
    logic shift_or_scroll_select;
    logic invert_whole_display;
    logic glyph_blink_enable;
    logic low_power_select;
    logic segment_order;
    logic increment;
    logic shift_on_write;
    logic extended_register_enable;
    logic sleep_request;
    logic [3:0] line_shift_enables;
    logic [3:0] line_scroll_enables;
    logic [5:0] scroll_amount;
  } cld_cfg_t;

  localparam cld_cfg_t CFG_RESET = '{
    bus_width_select: RST_BUS_WIDTH_8,
    increment: RST_INCREMENT,
    default: '0
  };

endpackage

// *** testbench/cld_host.sv ***
// Host processor model that drives the parallel bus of the decoder.
`timescale 1ns/1ps
module cld_host #(
  parameter int HALF_OSC = 185
) (
  input wire logic clock,
  input wire logic busy_flag,
  input wire logic [7:0] data_out,
  output logic register_select,
  output logic read_write,
  output logic strobe,
  output logic [7:0] data_in
);
  logic four_bit = 1'b0;
  int busy_n = 0;
  int run = 0;
  int last_run = 0;
  int n_runs = 0;

  initial begin
    register_select = 1'b0;
    read_write = 1'b0;
    strobe = 1'b0;
    data_in = 8'h00;
  end

  // Length of the last busy period, measured on the port itself.
  always @(posedge clock) begin
    if (busy_flag) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        last_run <= run;
        n_runs <= n_runs + 1;
      end
      run <= 0;
    end
  end

  // A read releases the data lines, so they show the inverse of the last
  // value instead of a stale copy that could pass by luck.
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] v,
                       output logic [7:0] rd);
    @(negedge clock);
    register_select = rs;
    read_write = rw;
    data_in = rw ? ~data_in : v;
    strobe = 1'b1;
    repeat (6) @(negedge clock);
    rd = data_out;
    strobe = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] v,
                      input bit wt, output logic [7:0] rd);
    logic [7:0] hi;
    int start;
    start = n_runs;
    if (four_bit) begin
      pulse(rs, rw, {v[7:4], ~v[7:4]}, hi);
      pulse(rs, rw, {v[3:0], ~v[3:0]}, rd);
      rd = {hi[7:4], rd[7:4]};
    end else
      pulse(rs, rw, v, rd);
    if (wt && !(rs == 1'b0 && rw == 1'b1)) begin
      for (int i = 0; i < 100000 && busy_flag; i++) @(negedge clock);
      repeat (HALF_OSC) @(negedge clock);
    end
    busy_n = (n_runs != start) ? last_run : 0;
  endtask
endmodule

// *** testbench/cld_decoder_tb_top.sv ***
// Self-checking testbench of the character display instruction decoder.
`timescale 1ns/1ps
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin \
  n_errors++; $display("[FAIL] %0t %s", $time, m); end end
module cld_decoder_tb_top;
  import cld_pkg::*;
  localparam int LONG_C = 20;
  localparam int CTRL_C = 10;
  localparam int DATA_C = 12;
  localparam int BLINK_C = 50;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instruction_set_select = 1'b1;
  logic register_select, read_write, strobe, data_oe, busy_flag;
  logic [7:0] data_in, data_out, rd, v;
  logic [6:0] address_counter, display_offset, a, s;
  logic cursor_blink_phase, rows_cols_to_supply, ext_driver_d;
  logic ext_driver_m, converter_enable, w1;
  logic [ICON_DEPTH-1:0][7:0] icon_bits;
  cld_cfg_t cfg, keep;
  logic [7:0] txt [128];
  logic [7:0] gly [64];
  logic [7:0] ico [16];
  int ac = 0, sel = 0, n = 0, n_errors = 0, comparisons = 0;
  bit inc = 1'b1;
  logic [31:0] seed = 32'd35;

  cld_decoder #(.LONG_CYCLES(LONG_C), .CTRL_CYCLES(CTRL_C),
    .DATA_CYCLES(DATA_C), .BLINK_CYCLES(BLINK_C)) dut (.clock(clock),
    .rst(rst), .instruction_set_select(instruction_set_select),
    .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .busy_flag(busy_flag),
    .address_counter(address_counter), .cfg(cfg),
    .display_offset(display_offset),
    .cursor_blink_phase(cursor_blink_phase),
    .rows_cols_to_supply(rows_cols_to_supply),
    .ext_driver_d(ext_driver_d), .ext_driver_m(ext_driver_m),
    .converter_enable(converter_enable), .icon_bits(icon_bits));

  cld_host host (.clock(clock), .busy_flag(busy_flag), .data_out(data_out),
    .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .data_in(data_in));

  initial begin
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int msk();
    return sel == 0 ? 127 : sel == 1 ? 63 : 15;
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c, input int bz);
    host.xfer(1'b0, 1'b0, c, 1'b1, rd);
    `CHK(host.busy_n, bz, "busy length")
  endtask

  task automatic setad(input logic [7:0] c, input int sl);
    cmd(c, CTRL_C);
    sel = sl;
    ac = c & msk();
    `CHK(address_counter, 7'(ac), "address set")
  endtask

  task automatic step();
    ac = (inc ? ac + 1 : ac - 1) & msk();
    `CHK(address_counter, 7'(ac), "address step")
  endtask

  task automatic wr(input logic [7:0] d);
    host.xfer(1'b1, 1'b0, d, 1'b1, rd);
    `CHK(host.busy_n, DATA_C, "data busy")
    if (sel == 0) txt[ac] = d;
    else if (sel == 1) gly[ac] = d;
    else ico[ac] = d;
    step();
  endtask

  task automatic rdd();
    logic [7:0] e;
    e = sel == 0 ? txt[ac] : sel == 1 ? gly[ac] : ico[ac];
    host.xfer(1'b1, 1'b1, 8'h00, 1'b1, rd);
    `CHK(rd, e, "read data")
    step();
  endtask

  task automatic stat(input logic b);
    host.xfer(1'b0, 1'b1, 8'h00, 1'b0, rd);
    `CHK(rd, {b, 7'(ac)}, "status")
    `CHK(data_oe, 1'b0, "bus released")
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    give_verdict();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) txt[i] = SPACE_CODE;
    for (int i = 0; i < 64; i++) gly[i] = 8'h00;
    for (int i = 0; i < 16; i++) ico[i] = 8'h00;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    `CHK(cfg, CFG_RESET, "reset cfg")
    `CHK(converter_enable, 1'b1, "reset converter")
    stat(1'b0);
    for (int i = 0; i < 4; i++) begin
      v = 8'h30 | (8'(rnd()) & 8'h0B);
      cmd(v, CTRL_C);
      `CHK({cfg.two_line, cfg.shift_or_scroll_select,
        cfg.invert_whole_display, cfg.extended_register_enable},
        {v[3], v[1], v[0], 1'b0}, "function set")
    end
    instruction_set_select = 1'b0;
    keep = cfg;
    repeat (4) @(negedge clock);
    cmd(v ^ 8'h02, 0);
    `CHK(cfg, keep, "set select low")
    instruction_set_select = 1'b1;
    repeat (4) @(negedge clock);
    $display("test function set done");
    for (int i = 0; i < 8; i++) begin
      cmd(8'h08 | 8'(i), CTRL_C);
      `CHK({cfg.panel_on, cfg.cursor_on, cfg.cursor_blink}, 3'(i), "disp")
    end
    for (int k = 0; k < 2; k++) begin
      w1 = cursor_blink_phase;
      n = 0;
      while (cursor_blink_phase === w1 && n < 1000) begin
        @(negedge clock);
        n++;
      end
    end
    `CHK(n, BLINK_C, "blink period")
    $display("test display control done");
    a = 7'(rnd());
    setad(8'h80 | 8'(a), 0);
    cmd(8'h06, CTRL_C);
    repeat (3) wr(8'(rnd()));
    cmd(8'h04, CTRL_C);
    inc = 1'b0;
    wr(8'(rnd()));
    setad(8'h80 | 8'(a), 0);
    repeat (3) rdd();
    setad(8'h40 | 8'h21, 1);
    repeat (2) wr(8'(rnd()));
    setad(8'h40 | 8'h21, 1);
    repeat (2) rdd();
    cmd(8'h34, CTRL_C);
    setad(8'h4A, 2);
    v = 8'(rnd());
    wr(v);
    `CHK(icon_bits[10], v, "icon bits")
    setad(8'h4A, 2);
    rdd();
    $display("test ram access done");
    cmd(8'h30, CTRL_C);
    setad(8'hA0, 0);
    cmd(8'h14, CTRL_C);
    ac++;
    `CHK(address_counter, 7'(ac), "cursor right")
    cmd(8'h10, CTRL_C);
    ac--;
    `CHK(address_counter, 7'(ac), "cursor left")
    cmd(8'h1C, CTRL_C);
    s = display_offset;
    `CHK(s === 7'h01 || s === 7'h7F, 1'b1, "display right")
    cmd(8'h18, CTRL_C);
    `CHK(display_offset, 7'h00, "display left")
    cmd(8'h07, CTRL_C);
    inc = 1'b1;
    wr(8'(rnd()));
    `CHK(display_offset, 7'(128 - s), "shift on write")
    rdd();
    setad(8'h40, 1);
    wr(8'(rnd()));
    `CHK(display_offset, 7'(128 - s), "no shift")
    cmd(8'h02, LONG_C);
    sel = 0;
    ac = 0;
    `CHK({display_offset, address_counter}, 14'h0000, "home")
    setad(8'h80 | 8'(a), 0);
    rdd();
    $display("test shift and home done");
    cmd(8'h04, CTRL_C);
    cmd(OP_CLEAR, LONG_C);
    for (int i = 0; i < 128; i++) txt[i] = SPACE_CODE;
    ac = 0;
    inc = 1'b1;
    `CHK({cfg.increment, address_counter}, 8'h80, "clear")
    rdd();
    setad(8'h80 | 8'(a), 0);
    rdd();
    host.xfer(1'b0, 1'b0, 8'h02, 1'b0, rd);
    ac = 0;
    stat(1'b1);
    repeat (200) @(negedge clock);
    $display("test clear and busy done");
    for (int i = 0; i < 4; i++) begin
      v = 8'(rnd());
      cmd(8'h30 | {6'h00, i[0], 1'b0}, CTRL_C);
      cmd(8'h34 | (v & 8'h0B), CTRL_C);
      `CHK({cfg.extended_register_enable, cfg.two_line,
        cfg.glyph_blink_enable, cfg.low_power_select},
        {1'b1, v[3], v[1], v[0]}, "ext function set")
      cmd(8'h02 | {7'h00, v[4]}, CTRL_C);
      `CHK({rows_cols_to_supply, ext_driver_d, ext_driver_m,
        converter_enable}, {v[4], v[4], 1'b0, ~v[4]}, "sleep")
      cmd(8'h06 | {7'h00, v[5]}, CTRL_C);
      `CHK(cfg.segment_order, v[5], "segment order")
      cmd(8'h08 | {5'h00, v[2:0]}, CTRL_C);
      `CHK({cfg.wide_font, cfg.cursor_invert, cfg.four_line_select},
        v[2:0], "ext function")
      cmd(8'h10 | {4'h0, v[7:4]}, CTRL_C);
      `CHK(i[0] ? cfg.line_shift_enables : cfg.line_scroll_enables,
        v[7:4], "line enables")
      cmd(8'h80 | v, CTRL_C);
      `CHK(cfg.scroll_amount, v[5:0], "scroll amount")
    end
    $display("test extended done");
    cmd(8'h20, CTRL_C);
    host.four_bit = 1'b1;
    `CHK(cfg.bus_width_select, 1'b0, "four bit")
    setad(8'hC5, 0);
    wr(8'(rnd()));
    setad(8'hC5, 0);
    rdd();
    stat(1'b0);
    cmd(8'h30, CTRL_C);
    host.four_bit = 1'b0;
    `CHK(cfg.bus_width_select, 1'b1, "eight bit")
    $display("test nibble mode done");
    give_verdict();
  end
endmodule
